// ===== rtl/charger_ctrl.sv
// Purpose: mode select, charge sequencing and status pins of the charger
// Assumes: analog comparators deliver clean levels; pins are asynchronous
// Notes: registers reached over classic Wishbone, 32-bit words
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
module charger_ctrl
	import charger_pkg::*;
#(
	parameter int PULSE_CYC = INT_PULSE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic ack_o,
	output logic [31:0] dat_o,
	// host pins
	input wire logic src_usb_i,
	input wire logic boost_enable_pin_i,
	input wire logic charge_en_n_i,
	// analog sense levels
	input wire logic thermistor_sense_a_i,
	input wire logic thermistor_sense_b_i,
	input wire logic vbat_low_i,
	input wire logic vbat_at_reg_i,
	input wire logic ichg_below_term_i,
	input wire logic vbat_below_rechg_i,
	input wire logic tj_over_reg_i,
	input wire logic vin_in_window_i,
	input wire logic vin_above_sleep_i,
	input wire logic input_limit_reached_i,
	input wire logic load_exceeds_i,
	input wire logic fault_i,
	input wire logic [2:0] current_limit_resistor_pin_i,
	// open-drain status pins
	output logic int_n_o,
	output logic int_oe_o,
	output logic stat_n_o,
	output logic stat_oe_o,
	output logic stat_fault_pd_o,
	output logic good_source_n_o,
	output logic good_source_oe_o,
	// power stage controls
	output logic boost_o,
	output logic charge_en_o,
	output logic [2:0] input_limit_o,
	output logic [1:0] charge_phase_o,
	output logic charge_reduce_o,
	output logic [1:0] treg_code_o,
	output logic [2:0] sysmin_code_o,
	output logic charge_zero_o,
	output logic supplement_o
);

	////////////////////////////////////////////////////////////////////
	// pin synchronisation

	sense_t raw;
	sense_t s;
	logic pulse_act;
	logic int_start;

	always_comb begin
		raw.src_usb = src_usb_i;
		raw.boost_pin = boost_enable_pin_i;
		raw.charge_en_n = charge_en_n_i;
		raw.therm_a = thermistor_sense_a_i;
		raw.therm_b = thermistor_sense_b_i;
		raw.vbat_low = vbat_low_i;
		raw.vbat_at_reg = vbat_at_reg_i;
		raw.ichg_term = ichg_below_term_i;
		raw.vbat_rechg = vbat_below_rechg_i;
		raw.tj_over = tj_over_reg_i;
		raw.vin_window = vin_in_window_i;
		raw.vin_awake = vin_above_sleep_i;
		raw.limit_hit = input_limit_reached_i;
		raw.load_high = load_exceeds_i;
		raw.fault = fault_i;
		raw.res_lim = current_limit_resistor_pin_i;
	end

	level_sync #(
		.W($bits(sense_t)),
		.RST_VAL(SENSE_RST)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(raw),
		.q_o(s)
	);

	int_pulse #(
		.LEN(PULSE_CYC)
	) u_int (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(int_start),
		.active_o(pulse_act)
	);

	////////////////////////////////////////////////////////////////////
	// mode decode

	top_state_t cur_ff;
	top_state_t nxt_cur;
	logic boost_cond;
	logic chg_cond;
	logic therm_bad;
	logic run_ok;
	logic good_cond;
	logic [2:0] usb_lim;
	logic [2:0] lim_cond;
	logic req;
	logic [31:0] status_word;

	always_comb begin
		boost_cond = (cur_ff.mode == MODE_BOOST) && s.boost_pin;
		// other mode codes fall through with both off
		chg_cond = (cur_ff.mode == MODE_CHARGE) && !s.charge_en_n;
		therm_bad = s.therm_a || s.therm_b;
		run_ok = chg_cond && !s.fault && !therm_bad;
		// usb host source: boost pin picks 500 or 100
		usb_lim = s.boost_pin ? LIM_500 : LIM_100;
		lim_cond = lim_min(cur_ff.lim, s.res_lim);
		if (s.src_usb && !boost_cond) begin
			lim_cond = lim_min(lim_cond, usb_lim);
		end
		good_cond = s.vin_window && s.vin_awake
			&& (lim_ma(lim_cond) > LIM_FLOOR_MA);
	end

	////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		nxt_cur = cur_ff;
		req = cyc_i && stb_i && !cur_ff.ack;
		status_word = '0;
		status_word[STS_ST_LSB +: 7] = cur_ff.st;
		status_word[STS_FLAG_LSB +: 4] = {cur_ff.supplement, cur_ff.chg_en,
			cur_ff.boost, cur_ff.good_oe};
		status_word[STS_LIM_LSB +: 3] = cur_ff.eff_lim;

		// bus slave: one wait state, ack for one cycle
		nxt_cur.ack = req;
		nxt_cur.rdata = '0;
		if (req) begin
			case (adr_i)
				OFS_CTRL: begin
					nxt_cur.rdata[LIM_LSB +: 3] = cur_ff.lim;
					nxt_cur.rdata[MODE_LSB +: 2] = cur_ff.mode;
					if (we_i && sel_i[0]) begin
						nxt_cur.lim = dat_i[LIM_LSB +: 3];
						nxt_cur.mode = dat_i[MODE_LSB +: 2];
					end
				end
				OFS_THERM: begin
					nxt_cur.rdata[TREG_LSB +: 2] = cur_ff.treg;
					nxt_cur.rdata[SYSMIN_LSB +: 3] = cur_ff.sysmin;
					if (we_i && sel_i[0]) begin
						nxt_cur.treg = dat_i[TREG_LSB +: 2];
						nxt_cur.sysmin = dat_i[SYSMIN_LSB +: 3];
					end
				end
				OFS_STATUS: begin
					nxt_cur.rdata = status_word;
				end
				default: begin
					nxt_cur.rdata = '0;
				end
			endcase
		end

		// charge sequencer, needs no software once enabled
		if (!chg_cond) begin
			nxt_cur.st = ST_IDLE;
		end else if (s.fault) begin
			nxt_cur.st = ST_FAULT;
		end else if (therm_bad) begin
			nxt_cur.st = ST_SUSP;
		end else begin
			case (cur_ff.st)
				ST_IDLE: begin
					if (s.vbat_low) begin
						nxt_cur.st = ST_PRE;
					end else if (s.vbat_at_reg) begin
						nxt_cur.st = ST_CV;
					end else begin
						nxt_cur.st = ST_CC;
					end
				end
				ST_PRE: begin
					if (!s.vbat_low) begin
						nxt_cur.st = ST_CC;
					end
				end
				ST_CC: begin
					if (s.vbat_low) begin
						nxt_cur.st = ST_PRE;
					end else if (s.vbat_at_reg) begin
						nxt_cur.st = ST_CV;
					end
				end
				ST_CV: begin
					if (s.ichg_term) begin
						nxt_cur.st = ST_DONE;
					end
				end
				ST_DONE: begin
					if (s.vbat_rechg) begin
						nxt_cur.st = ST_IDLE;
					end
				end
				ST_SUSP: begin
					nxt_cur.st = ST_IDLE;
				end
				ST_FAULT: begin
					nxt_cur.st = ST_IDLE;
				end
				default: begin
					nxt_cur.st = ST_IDLE;
				end
			endcase
		end

		// pin drivers
		nxt_cur.int_oe = pulse_act;
		nxt_cur.stat_oe = (cur_ff.st == ST_PRE) || (cur_ff.st == ST_CC)
			|| (cur_ff.st == ST_CV);
		nxt_cur.stat_fault = (cur_ff.st == ST_FAULT);
		nxt_cur.good_oe = good_cond;
		nxt_cur.boost = boost_cond;
		nxt_cur.chg_en = nxt_cur.stat_oe;
		nxt_cur.eff_lim = lim_cond;
		nxt_cur.chg_reduce = s.tj_over;
		nxt_cur.chg_zero = s.limit_hit;
		nxt_cur.supplement = s.limit_hit && s.load_high;
	end

	// a phase change, or a fault arrival while charging is enabled, raises the interrupt
	assign int_start = (nxt_cur.st != cur_ff.st);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_ff <= '0;
			cur_ff.lim <= LIM_RST;
			cur_ff.mode <= MODE_RST;
			cur_ff.treg <= TREG_RST;
			cur_ff.sysmin <= SYSMIN_RST;
			cur_ff.st <= ST_IDLE;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	assign ack_o = cur_ff.ack;
	assign dat_o = cur_ff.rdata;
	assign int_n_o = 1'b0;
	assign int_oe_o = cur_ff.int_oe;
	assign stat_n_o = 1'b0;
	assign stat_oe_o = cur_ff.stat_oe;
	assign stat_fault_pd_o = cur_ff.stat_fault;
	assign good_source_n_o = 1'b0;
	assign good_source_oe_o = cur_ff.good_oe;
	assign boost_o = cur_ff.boost;
	assign charge_en_o = cur_ff.chg_en;
	assign input_limit_o = cur_ff.eff_lim;
	assign charge_phase_o = {cur_ff.st == ST_CV || cur_ff.st == ST_DONE,
		cur_ff.st == ST_CC || cur_ff.st == ST_DONE};
	assign charge_reduce_o = cur_ff.chg_reduce;
	assign treg_code_o = cur_ff.treg;
	assign sysmin_code_o = cur_ff.sysmin;
	assign charge_zero_o = cur_ff.chg_zero;
	assign supplement_o = cur_ff.supplement;

	////////////////////////////////////////////////////////////////////
	// checks

	property p_boost;
		@(posedge clk_i) disable iff (rst_i)
		##1 boost_o == $past(boost_cond);
	endproperty
	a_boost: assert property (p_boost) else $error("boost enable mismatch");

	property p_mode_off;
		@(posedge clk_i) disable iff (rst_i)
		(cur_ff.mode != MODE_CHARGE && cur_ff.mode != MODE_BOOST) |=> !boost_o ##1 !charge_en_o;
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("odd mode not idle");

	property p_chg_gate;
		@(posedge clk_i) disable iff (rst_i)
		!chg_cond |=> cur_ff.st == ST_IDLE ##1 !charge_en_o;
	endproperty
	a_chg_gate: assert property (p_chg_gate) else $error("charge without enable");

	property p_usb_lim;
		@(posedge clk_i) disable iff (rst_i)
		(s.src_usb && !s.boost_pin) |=> input_limit_o == LIM_100;
	endproperty
	a_usb_lim: assert property (p_usb_lim) else $error("usb 100mA limit lost");

	property p_lim_min;
		@(posedge clk_i) disable iff (rst_i)
		##1 (input_limit_o <= $past(s.res_lim)) && (input_limit_o <= $past(cur_ff.lim));
	endproperty
	a_lim_min: assert property (p_lim_min) else $error("limit above a source");

	property p_stat_fault;
		@(posedge clk_i) disable iff (rst_i)
		cur_ff.st == ST_FAULT |=> stat_fault_pd_o && !stat_oe_o;
	endproperty
	a_stat_fault: assert property (p_stat_fault) else $error("fault not shown");

	property p_stat_chg;
		@(posedge clk_i) disable iff (rst_i)
		(cur_ff.st == ST_CC || cur_ff.st == ST_DONE) |=> stat_oe_o == ($past(cur_ff.st) != ST_DONE);
	endproperty
	a_stat_chg: assert property (p_stat_chg) else $error("status pin wrong");

	property p_therm;
		@(posedge clk_i) disable iff (rst_i)
		(therm_bad && chg_cond && !s.fault) |=> cur_ff.st == ST_SUSP ##1 !charge_en_o;
	endproperty
	a_therm: assert property (p_therm) else $error("no thermistor suspend");

	property p_term;
		@(posedge clk_i) disable iff (rst_i)
		(cur_ff.st == ST_CV && s.ichg_term && run_ok) |=> cur_ff.st == ST_DONE;
	endproperty
	a_term: assert property (p_term) else $error("no termination");

	property p_rechg;
		@(posedge clk_i) disable iff (rst_i)
		(cur_ff.st == ST_DONE && s.vbat_rechg && run_ok) |=> cur_ff.st == ST_IDLE;
	endproperty
	a_rechg: assert property (p_rechg) else $error("no recharge");

	property p_good;
		@(posedge clk_i) disable iff (rst_i)
		##1 good_source_oe_o == $past(good_cond);
	endproperty
	a_good: assert property (p_good) else $error("good source mismatch");

	property p_int_event;
		@(posedge clk_i) disable iff (rst_i)
		(int_start && !pulse_act) |=> ##1 int_oe_o;
	endproperty
	a_int_event: assert property (p_int_event) else $error("event gave no pulse");

	property p_supp;
		@(posedge clk_i) disable iff (rst_i)
		(s.limit_hit && s.load_high) |=> supplement_o && charge_zero_o;
	endproperty
	a_supp: assert property (p_supp) else $error("no supplement");
endmodule

// ===== rtl/charger_pkg.sv
// Purpose: shared constants and types of the charger control block
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: comparator results arrive as digital levels from the analog side
//
// Overview of operation
// - Source select high means USB host source, low means wall adapter.
// - USB source in buck mode: boost pin high gives 500mA, low 100mA.
// - Boost mode only when mode field is 10 and boost pin high.
// - Charging only when mode field is 01 and charge enable pin low.
// - Applied input limit is the lower of resistor and field limits.
// - Input limit field offers eight settings from 100mA up to 3A.
// - Status changes and faults give one 256us low pulse on interrupt pin; faults only while charging is enabled.
// - Charge status pin low while charging, released when done or disabled.
// - A fault while charging is enabled gives charge status pin a distinct third indication.
// - Good-source low only with input in window, above sleep, limit over 30mA.
// - Charge runs preconditioning, constant current, constant voltage by battery voltage.
// - Constant voltage phase ends when charge current drops below termination.
// - After termination a new cycle starts when battery falls below recharge.
// - Full charge cycles run on their own, software not needed.
// - Either thermistor input out of range suspends charging.
// - Junction above programmable threshold, default 120C, reduces charge current.
// - System held above battery, never below programmable minimum, default 3.5V.
// - Input current or voltage limit reached drives charge current to zero.
// - Load rising further at zero charge current enters battery supplement mode.
package charger_pkg;

	localparam int CLK_MHZ = 100;
	localparam int INT_PULSE_US = 256;
	localparam int INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
	localparam int PULSE_CNT_W = 16;

	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_THERM = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;

	localparam int LIM_LSB = 0;
	localparam int MODE_LSB = 4;
	localparam int TREG_LSB = 0;
	localparam int SYSMIN_LSB = 4;
	localparam int STS_ST_LSB = 0;
	localparam int STS_FLAG_LSB = 8;
	localparam int STS_LIM_LSB = 12;

	localparam logic [2:0] LIM_RST = 3'h2;
	localparam logic [1:0] MODE_RST = 2'h1;
	localparam logic [1:0] TREG_RST = 2'h3;
	localparam logic [2:0] SYSMIN_RST = 3'h5;

	localparam logic [1:0] MODE_CHARGE = 2'h1;
	localparam logic [1:0] MODE_BOOST = 2'h2;
	localparam logic [2:0] LIM_100 = 3'h0;
	localparam logic [2:0] LIM_500 = 3'h2;
	localparam logic [11:0] LIM_FLOOR_MA = 12'h01e;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_PRE = 7'h02,
		ST_CC = 7'h04,
		ST_CV = 7'h08,
		ST_DONE = 7'h10,
		ST_SUSP = 7'h20,
		ST_FAULT = 7'h40
	} chg_state_t;

	typedef struct packed {
		logic src_usb;
		logic boost_pin;
		logic charge_en_n;
		logic therm_a;
		logic therm_b;
		logic vbat_low;
		logic vbat_at_reg;
		logic ichg_term;
		logic vbat_rechg;
		logic tj_over;
		logic vin_window;
		logic vin_awake;
		logic limit_hit;
		logic load_high;
		logic fault;
		logic [2:0] res_lim;
	} sense_t;

	// synchroniser contents after reset: every pin at its idle level
	localparam sense_t SENSE_RST = '{charge_en_n: 1'b1, default: '0};

	typedef struct packed {
		logic [2:0] lim;
		logic [1:0] mode;
		logic [1:0] treg;
		logic [2:0] sysmin;
		logic ack;
		logic [31:0] rdata;
		chg_state_t st;
		logic int_oe;
		logic stat_oe;
		logic stat_fault;
		logic good_oe;
		logic boost;
		logic chg_en;
		logic [2:0] eff_lim;
		logic chg_reduce;
		logic chg_zero;
		logic supplement;
	} top_state_t;

	// input limit code to milliamps
	function automatic logic [11:0] lim_ma(input logic [2:0] code);
		case (code)
			3'h0: lim_ma = 12'h064;
			3'h1: lim_ma = 12'h096;
			3'h2: lim_ma = 12'h1f4;
			3'h3: lim_ma = 12'h384;
			3'h4: lim_ma = 12'h4b0;
			3'h5: lim_ma = 12'h5dc;
			3'h6: lim_ma = 12'h7d0;
			default: lim_ma = 12'hbb8;
		endcase
	endfunction

	function automatic logic [2:0] lim_min(input logic [2:0] a, input logic [2:0] b);
		lim_min = (a < b) ? a : b;
	endfunction

endpackage

// ===== rtl/level_sync.sv
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: inputs are quasi-static levels
// Notes: first stage feeds only the second
module level_sync
	import charger_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] safe;
	} sync_state_t;

	sync_state_t cur_ff;
	sync_state_t nxt_cur;

	always_comb begin
		nxt_cur.meta = d_i;
		nxt_cur.safe = cur_ff.meta;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_ff.meta <= RST_VAL;
			cur_ff.safe <= RST_VAL;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign q_o = cur_ff.safe;
endmodule

// ===== rtl/int_pulse.sv
// Purpose: fixed-width interrupt pulse generator
// Assumes: start is a one-cycle pulse on clk_i
// Notes: starts while busy are dropped
module int_pulse
	import charger_pkg::*;
#(
	parameter int LEN = INT_PULSE_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic start_i,
	output logic active_o
);
	typedef struct packed {
		logic act;
		logic [PULSE_CNT_W-1:0] cnt;
	} pulse_state_t;

	localparam logic [PULSE_CNT_W-1:0] LAST = PULSE_CNT_W'(LEN - 1);

	pulse_state_t cur_ff;
	pulse_state_t nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		if (cur_ff.act) begin
			if (cur_ff.cnt == LAST) begin
				nxt_cur.act = 1'b0;
				nxt_cur.cnt = '0;
			end else begin
				nxt_cur.cnt = cur_ff.cnt + 1'b1;
			end
		end else if (start_i) begin
			nxt_cur.act = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign active_o = cur_ff.act;

	property p_pulse_len;
		@(posedge clk_i) disable iff (rst_i)
		$fell(cur_ff.act) |-> $past(cur_ff.cnt) == LAST;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse width wrong");

	property p_no_merge;
		@(posedge clk_i) disable iff (rst_i)
		(cur_ff.act && start_i && cur_ff.cnt != LAST) |=> cur_ff.act && cur_ff.cnt != '0;
	endproperty
	a_no_merge: assert property (p_no_merge) else $error("pulse cut by event");
endmodule

// ===== verif/host_side_model.sv
// Purpose: host-side view of the open-drain status pins
// Assumes: pull-ups to the logic rail; the fault path pulls to a mid level
// Notes: stat_lvl_o is 0 low, 1 mid (fault), 3 high
module host_side_model (
	// device pin drivers
	input wire logic int_n_i,
	input wire logic int_oe_i,
	input wire logic stat_n_i,
	input wire logic stat_oe_i,
	input wire logic stat_fault_pd_i,
	input wire logic good_source_n_i,
	input wire logic good_source_oe_i,
	// resolved levels
	output logic int_pin_o,
	output logic [1:0] stat_lvl_o,
	output logic good_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign int_pin_o = int_oe_i ? int_n_i : 1'b1;
	assign stat_lvl_o = stat_oe_i ? {2{stat_n_i}} : (stat_fault_pd_i ? 2'h1 : 2'h3);
	assign good_pin_o = good_source_oe_i ? good_source_n_i : 1'b1;
endmodule

// ===== verif/charger_mode_status_control_tb_top.sv
// Purpose: self-checking bench of the charger control block
// Assumes: pulse length shortened to 20 cycles
// Notes: pins change on the rising edge; registers via classic Wishbone
module charger_mode_status_control_tb_top;
	import charger_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PLEN = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [3:0] adr_i = 4'h0, sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0, dat_o, d;
	logic ack_o, src_usb_i = 1'b0, boost_enable_pin_i = 1'b0, charge_en_n_i = 1'b1;
	logic thermistor_sense_a_i = 1'b0, thermistor_sense_b_i = 1'b0, vbat_low_i = 1'b0;
	logic vbat_at_reg_i = 1'b0, ichg_below_term_i = 1'b0, vbat_below_rechg_i = 1'b0;
	logic tj_over_reg_i = 1'b0, vin_in_window_i = 1'b0, vin_above_sleep_i = 1'b0;
	logic input_limit_reached_i = 1'b0, load_exceeds_i = 1'b0, fault_i = 1'b0;
	logic [2:0] current_limit_resistor_pin_i = 3'h7, input_limit_o, sysmin_code_o;
	logic int_n_o, int_oe_o, stat_n_o, stat_oe_o, stat_fault_pd_o, good_source_n_o, good_source_oe_o;
	logic boost_o, charge_en_o, charge_reduce_o, charge_zero_o, supplement_o, int_pin, good_pin;
	logic [1:0] charge_phase_o, treg_code_o, stat_lvl;
	int fail_count = 0, checks_done = 0, n, len;
	always #5 clk_i = ~clk_i;
	charger_ctrl #(.PULSE_CYC(PLEN)) u_charger_ctrl (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
		.dat_i, .ack_o, .dat_o, .src_usb_i, .boost_enable_pin_i, .charge_en_n_i, .thermistor_sense_a_i,
		.thermistor_sense_b_i, .vbat_low_i, .vbat_at_reg_i, .ichg_below_term_i, .vbat_below_rechg_i,
		.tj_over_reg_i, .vin_in_window_i, .vin_above_sleep_i, .input_limit_reached_i, .load_exceeds_i,
		.fault_i, .current_limit_resistor_pin_i, .int_n_o, .int_oe_o, .stat_n_o, .stat_oe_o,
		.stat_fault_pd_o, .good_source_n_o, .good_source_oe_o, .boost_o, .charge_en_o, .input_limit_o,
		.charge_phase_o, .charge_reduce_o, .treg_code_o, .sysmin_code_o, .charge_zero_o, .supplement_o);
	host_side_model u_host_side_model (.int_n_i(int_n_o), .int_oe_i(int_oe_o), .stat_n_i(stat_n_o),
		.stat_oe_i(stat_oe_o), .stat_fault_pd_i(stat_fault_pd_o), .good_source_n_i(good_source_n_o),
		.good_source_oe_i(good_source_oe_o), .int_pin_o(int_pin), .stat_lvl_o(stat_lvl),
		.good_pin_o(good_pin));
	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (fail_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int k;
		k = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= wd;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		rd = dat_o;
		if (k >= 50) chk(32'(ack_o), 32'h1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] wd);
		logic [31:0] dummy;
		wb(1'b1, a, wd, dummy);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		chk(r & m, exp);
	endtask
	task automatic settle;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic int_quiet;
		n = 0;
		while (int_pin !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		fail_count++;
		wrap_up();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd_chk(OFS_CTRL, 32'hffffffff, 32'h12);
		rd_chk(OFS_THERM, 32'hffffffff, 32'h53);
		wr(4'hc, 32'hff);
		rd_chk(4'hc, 32'hffffffff, 32'h0);
		sel_i <= 4'he;
		wr(OFS_CTRL, 32'h25);
		sel_i <= 4'hf;
		rd_chk(OFS_CTRL, 32'hffffffff, 32'h12);
		wr(OFS_THERM, 32'h21);
		settle();
		chk(32'(treg_code_o), 32'h1);
		chk(32'(sysmin_code_o), 32'h2);
		// adapter source: field code passes when resistor allows all
		for (int i = 0; i < 8; i++) begin
			wr(OFS_CTRL, 32'h10 | i);
			settle();
			chk(32'(input_limit_o), i);
			rd_chk(OFS_STATUS, 32'h7000, i << 12);
		end
		current_limit_resistor_pin_i <= 3'h3;
		settle();
		chk(32'(input_limit_o), 32'h3);
		current_limit_resistor_pin_i <= 3'h7;
		src_usb_i <= 1'b1;
		boost_enable_pin_i <= 1'b1;
		settle();
		chk(32'(input_limit_o), 32'(LIM_500));
		boost_enable_pin_i <= 1'b0;
		settle();
		chk(32'(input_limit_o), 32'(LIM_100));
		// mode field sweep with charging and boost requested
		charge_en_n_i <= 1'b0;
		boost_enable_pin_i <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CTRL, 32'h7 | (m << 4));
			settle();
			chk(32'(boost_o), 32'(m == 2));
			chk(32'(charge_en_o), 32'(m == 1));
		end
		wr(OFS_CTRL, 32'h27);
		settle();
		chk(32'(boost_o), 32'h1);
		boost_enable_pin_i <= 1'b0;
		settle();
		chk(32'(boost_o), 32'h0);
		src_usb_i <= 1'b0;
		charge_en_n_i <= 1'b1;
		vbat_low_i <= 1'b1;
		wr(OFS_CTRL, 32'h17);
		settle();
		chk(32'(charge_en_o), 32'h0);
		int_quiet();
		// enable charging; a state change during the pulse must not stretch it
		charge_en_n_i <= 1'b0;
		int_quiet();
		n = 0;
		while (int_pin !== 1'b0 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		len = 0;
		while (int_pin === 1'b0 && len < 100) begin
			@(posedge clk_i);
			len++;
			if (len == 5) vbat_low_i <= 1'b0;
		end
		chk(len, PLEN);
		n = 0;
		repeat (10) begin
			@(posedge clk_i);
			if (int_pin !== 1'b1) n++;
		end
		chk(n, 0);
		rd_chk(OFS_STATUS, 32'h7f, 32'(ST_CC));
		chk(32'(charge_phase_o), 32'h1);
		chk(32'(stat_lvl), 32'h0);
		vbat_at_reg_i <= 1'b1;
		settle();
		chk(32'(charge_phase_o), 32'h2);
		ichg_below_term_i <= 1'b1;
		settle();
		chk(32'(charge_phase_o), 32'h3);
		chk(32'(stat_lvl), 32'h3);
		ichg_below_term_i <= 1'b0;
		vbat_below_rechg_i <= 1'b1;
		settle();
		vbat_below_rechg_i <= 1'b0;
		settle();
		chk(32'(charge_phase_o), 32'h2);
		chk(32'(charge_en_o), 32'h1);
		for (int t = 0; t < 2; t++) begin
			thermistor_sense_a_i <= (t == 0);
			thermistor_sense_b_i <= (t == 1);
			settle();
			rd_chk(OFS_STATUS, 32'h7f, 32'(ST_SUSP));
			chk(32'(charge_en_o), 32'h0);
			thermistor_sense_a_i <= 1'b0;
			thermistor_sense_b_i <= 1'b0;
			settle();
			chk(32'(charge_en_o), 32'h1);
		end
		fault_i <= 1'b1;
		settle();
		chk(32'(stat_lvl), 32'h1);
		chk(32'(charge_en_o), 32'h0);
		fault_i <= 1'b0;
		tj_over_reg_i <= 1'b1;
		input_limit_reached_i <= 1'b1;
		settle();
		chk(32'(charge_reduce_o), 32'h1);
		chk(32'(charge_zero_o), 32'h1);
		chk(32'(supplement_o), 32'h0);
		load_exceeds_i <= 1'b1;
		settle();
		chk(32'(supplement_o), 32'h1);
		tj_over_reg_i <= 1'b0;
		input_limit_reached_i <= 1'b0;
		settle();
		chk(32'({charge_reduce_o, charge_zero_o, supplement_o}), 32'h0);
		for (int g = 0; g < 4; g++) begin
			vin_in_window_i <= g[0];
			vin_above_sleep_i <= g[1];
			settle();
			chk(32'(good_pin), 32'(g != 3));
		end
		wrap_up();
	end
endmodule
